//--- core/simd_alu_pkg.sv
// Package: opcodes, condition codes and widths of the packed-data ALU.
// Assumes: used by the ALU top, the lane interface, the checker and the testbench.
`default_nettype none
package simd_alu_pkg;
    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int unsigned WORD_W  = 32;
    localparam int unsigned HALF_W  = 16;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned REG_W   = 4;
    localparam int unsigned POS_W   = 4;
    localparam int unsigned HALVES  = 2;
    localparam int unsigned BYTES   = 4;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;
    localparam logic              SAT_RESET    = 1'b0;

    // ****************************************************************
    // flag positions in the nzcv vector
    // ****************************************************************
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_V = 0;

    // ****************************************************************
    // operations and condition codes
    // ****************************************************************
    typedef enum logic [1:0] {
        dual_lane_halving_add,
        quad_lane_halving_add,
        dual_signed_clamp,
        dual_unsigned_clamp
    } op_e;

    typedef enum logic [3:0] {
        cond_eq, cond_ne, cond_cs, cond_cc,
        cond_mi, cond_pl, cond_vs, cond_vc,
        cond_hi, cond_ls, cond_ge, cond_lt,
        cond_gt, cond_le, cond_al, cond_nv
    } cond_e;
endpackage : simd_alu_pkg
`default_nettype wire

//--- core/clamp_lane_if.sv
// Interface: one 16-bit lane between the ALU and a clamp lane.
// Assumes: purely combinational, no clock of its own.
`default_nettype none
interface clamp_lane_if;
    logic signed [simd_alu_pkg::HALF_W-1:0] value;
    logic        [simd_alu_pkg::POS_W-1:0]  pos;
    logic                                   unsigned_mode;
    logic        [simd_alu_pkg::HALF_W-1:0] result;
    logic                                   clamped;

    modport requester (output value, output pos, output unsigned_mode,
                       input result, input clamped);
    modport clamper   (input value, input pos, input unsigned_mode,
                       output result, output clamped);
endinterface : clamp_lane_if
`default_nettype wire

//--- core/lane_clamp.sv
// Lane clamp: saturates one signed halfword to a signed or unsigned range.
// Assumes: pos is the raw immediate; signed width is pos+1, unsigned pos.
`default_nettype none
module lane_clamp (
    clamp_lane_if.clamper lane
);
    // ****************************************************************
    // range limits
    // ****************************************************************
    // signed width is pos+1, so its top magnitude is one shifted by pos
    wire logic signed [17:0] one = 18'sh00001;
    wire logic signed [17:0] s_max = (one <<< lane.pos) - one;
    wire logic signed [17:0] s_min = -(one <<< lane.pos);
    wire logic signed [17:0] u_max = (one <<< lane.pos) - one;
    wire logic signed [17:0] u_min = 18'sh00000;
    wire logic signed [17:0] wide  = {{2{lane.value[15]}}, lane.value};
    wire logic signed [17:0] hi    = lane.unsigned_mode ? u_max : s_max;
    wire logic signed [17:0] lo    = lane.unsigned_mode ? u_min : s_min;

    // ****************************************************************
    // clamp
    // ****************************************************************
    wire logic over  = wide > hi;
    wire logic under = wide < lo;
    wire logic signed [17:0] sel = over ? hi : (under ? lo : wide);

    assign lane.result  = sel[15:0];
    assign lane.clamped = over | under;
endmodule : lane_clamp
`default_nettype wire

//--- core/simd_alu.sv
// Packed-data ALU: halving adds on 16/8-bit lanes and dual-lane clamps.
// Assumes: operands come from the register file on the core clock; the
// result is written back one cycle after issue by the caller.
`default_nettype none
module simd_alu (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 issue,
    input  wire simd_alu_pkg::op_e                    op,
    input  wire simd_alu_pkg::cond_e                  cond,
    input  wire logic                                 dest_present,
    input  wire logic [simd_alu_pkg::REG_W-1:0]       dest_index,
    input  wire logic [simd_alu_pkg::REG_W-1:0]       first_operand_register,
    input  wire logic [simd_alu_pkg::WORD_W-1:0]      first_value,
    input  wire logic [simd_alu_pkg::WORD_W-1:0]      second_value,
    input  wire logic [simd_alu_pkg::POS_W-1:0]       sat_pos,
    input  wire logic [3:0]                           nzcv,
    input  wire logic                                 sat_clear,
    output logic                                      write_en,
    output logic [simd_alu_pkg::REG_W-1:0]            write_index,
    output logic [simd_alu_pkg::WORD_W-1:0]           write_data,
    output logic                                      nzcv_write_en,
    output logic                                      sat_flag
);
    // ****************************************************************
    // predicate
    // ****************************************************************
    wire logic n = nzcv[simd_alu_pkg::FLAG_N];
    wire logic z = nzcv[simd_alu_pkg::FLAG_Z];
    wire logic c = nzcv[simd_alu_pkg::FLAG_C];
    wire logic v = nzcv[simd_alu_pkg::FLAG_V];
    logic pass;

    always_comb begin
        case (cond)
            simd_alu_pkg::cond_eq: pass = z;
            simd_alu_pkg::cond_ne: pass = !z;
            simd_alu_pkg::cond_cs: pass = c;
            simd_alu_pkg::cond_cc: pass = !c;
            simd_alu_pkg::cond_mi: pass = n;
            simd_alu_pkg::cond_pl: pass = !n;
            simd_alu_pkg::cond_vs: pass = v;
            simd_alu_pkg::cond_vc: pass = !v;
            simd_alu_pkg::cond_hi: pass = c & !z;
            simd_alu_pkg::cond_ls: pass = !c | z;
            simd_alu_pkg::cond_ge: pass = n == v;
            simd_alu_pkg::cond_lt: pass = n != v;
            simd_alu_pkg::cond_gt: pass = !z & (n == v);
            simd_alu_pkg::cond_le: pass = z | (n != v);
            default:               pass = 1'b1;
        endcase
    end

    wire logic go = issue & pass;

    // ****************************************************************
    // halving adds
    // ****************************************************************
    logic [simd_alu_pkg::WORD_W-1:0] half_add;
    logic [simd_alu_pkg::WORD_W-1:0] byte_add;

    genvar h;
    generate
        for (h = 0; h < simd_alu_pkg::HALVES; h++) begin : g_half
            wire logic [15:0] a = first_value[h*16 +: 16];
            wire logic [15:0] b = second_value[h*16 +: 16];
            wire logic [16:0] s = {a[15], a} + {b[15], b};
            assign half_add[h*16 +: 16] = s[16:1];
        end
        for (h = 0; h < simd_alu_pkg::BYTES; h++) begin : g_byte
            wire logic [7:0] a = first_value[h*8 +: 8];
            wire logic [7:0] b = second_value[h*8 +: 8];
            wire logic [8:0] s = {a[7], a} + {b[7], b};
            assign byte_add[h*8 +: 8] = s[8:1];
        end
    endgenerate

    // ****************************************************************
    // clamps
    // ****************************************************************
    logic [simd_alu_pkg::WORD_W-1:0] clamp_res;
    logic [simd_alu_pkg::HALVES-1:0] lane_hit;
    wire logic unsigned_op = op == simd_alu_pkg::dual_unsigned_clamp;

    generate
        for (h = 0; h < simd_alu_pkg::HALVES; h++) begin : g_clamp
            clamp_lane_if lane_bus ();
            assign lane_bus.value         = second_value[h*16 +: 16];
            assign lane_bus.pos           = sat_pos;
            assign lane_bus.unsigned_mode = unsigned_op;
            assign clamp_res[h*16 +: 16]  = lane_bus.result;
            assign lane_hit[h]            = lane_bus.clamped;
            lane_clamp u_clamp (.lane(lane_bus));
        end
    endgenerate

    // ****************************************************************
    // result select and write-back
    // ****************************************************************
    wire logic is_clamp = (op == simd_alu_pkg::dual_signed_clamp) |
                          unsigned_op;
    wire logic [simd_alu_pkg::WORD_W-1:0] next_write_data =
        (op == simd_alu_pkg::dual_lane_halving_add) ? half_add :
        (op == simd_alu_pkg::quad_lane_halving_add) ? byte_add : clamp_res;
    // destination omitted falls back to the first operand; the caller is
    // trusted not to name the stack pointer or program counter here
    wire logic [simd_alu_pkg::REG_W-1:0] next_write_index =
        dest_present ? dest_index : first_operand_register;
    wire logic sat_hit  = go & is_clamp & (|lane_hit);
    wire logic next_sat = sat_hit | (sat_flag & !sat_clear);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            write_en    <= 1'b0;
            write_index <= '0;
            write_data  <= simd_alu_pkg::RESULT_RESET;
            sat_flag    <= simd_alu_pkg::SAT_RESET;
        end else begin
            write_en <= go;
            sat_flag <= next_sat;
            if (go) begin
                write_index <= next_write_index;
                write_data  <= next_write_data;
            end
        end
    end

    // no operation of this unit ever writes negative/zero/carry/overflow
    assign nzcv_write_en = 1'b0;
endmodule : simd_alu
`default_nettype wire

//--- bench/reg_file_model.sv
// Partner: register file that takes the ALU's write-back.
// Assumes: fed from the write-back ports on the core clock.
`default_nettype none
module reg_file_model (
    input wire logic        clk,
    input wire logic        write_en,
    input wire logic [3:0]  write_index,
    input wire logic [31:0] write_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] regs [16];
    always @(posedge clk) begin
        if (write_en) regs[write_index] <= write_data;
    end
endmodule : reg_file_model
`default_nettype wire

//--- bench/simd_alu_asserts.sv
// Checker: port properties of the packed-data ALU.
// Assumes: one clock domain, synchronous active-low reset.
`default_nettype none
module simd_alu_asserts (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire logic                issue,
    input wire simd_alu_pkg::op_e   op,
    input wire simd_alu_pkg::cond_e cond,
    input wire logic                dest_present,
    input wire logic [3:0]          first_operand_register,
    input wire logic [31:0]         first_value,
    input wire logic [31:0]         second_value,
    input wire logic                sat_clear,
    input wire logic                write_en,
    input wire logic [3:0]          write_index,
    input wire logic [31:0]         write_data,
    input wire logic                nzcv_write_en,
    input wire logic                sat_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic go = issue && cond == simd_alu_pkg::cond_al;
    wire logic add = op == simd_alu_pkg::dual_lane_halving_add;
    wire logic uns = op == simd_alu_pkg::dual_unsigned_clamp;
    wire logic [16:0] s0 = {first_value[15], first_value[15:0]}
        + {second_value[15], second_value[15:0]};
    wire logic [16:0] s1 = {first_value[31], first_value[31:16]}
        + {second_value[31], second_value[31:16]};
    property p_keep; nzcv_write_en == 1'b0; endproperty
    a_keep: assert property (p_keep) else $error("flags");
    property p_pass; go |=> write_en; endproperty
    a_pass: assert property (p_pass) else $error("no write");
    property p_idle; !issue |=> !write_en; endproperty
    a_idle: assert property (p_idle) else $error("stray write");
    property p_hold;
        $past(reset_n) && !write_en |-> $stable(write_data);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_dst;
        go && !dest_present |=> write_index == $past(first_operand_register);
    endproperty
    a_dst: assert property (p_dst) else $error("index");
    property p_h16;
        go && add |=> write_data == {$past(s1[16:1]), $past(s0[16:1])};
    endproperty
    a_h16: assert property (p_h16) else $error("half add");
    property p_stk; sat_flag && !sat_clear |=> sat_flag; endproperty
    a_stk: assert property (p_stk) else $error("flag lost");
    property p_nos; !sat_flag && !issue |=> !sat_flag; endproperty
    a_nos: assert property (p_nos) else $error("flag set");
    property p_neg;
        go && uns && second_value[15] |=> sat_flag && write_data[15:0] == '0;
    endproperty
    a_neg: assert property (p_neg) else $error("unsigned");
    c_add: cover property (go && add);
    c_uns: cover property (go && uns);
    c_ref: cover property (issue && !go ##1 !write_en);
endmodule : simd_alu_asserts
bind simd_alu simd_alu_asserts chk_u (.clk(clk), .reset_n(reset_n),
    .issue(issue), .op(op), .cond(cond), .dest_present(dest_present),
    .first_operand_register(first_operand_register),
    .first_value(first_value), .second_value(second_value),
    .sat_clear(sat_clear), .write_en(write_en), .write_index(write_index),
    .write_data(write_data), .nzcv_write_en(nzcv_write_en),
    .sat_flag(sat_flag));
`default_nettype wire

//--- bench/testbench.sv
// Testbench: directed scenarios for the packed-data ALU.
// Assumes: design, checker and register file model compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, issue, dest_present, sat_clear;
    logic write_en, nzcv_write_en, sat_flag;
    logic [3:0] dest_index, first_operand_register, sat_pos, nzcv, write_index;
    logic [31:0] first_value, second_value, write_data;
    simd_alu_pkg::op_e op;
    simd_alu_pkg::cond_e cond;
    int n_fail = 0;
    int checked = 0;
    simd_alu dut_u (.clk(clk), .reset_n(reset_n), .issue(issue), .op(op),
        .cond(cond), .dest_present(dest_present), .dest_index(dest_index),
        .first_operand_register(first_operand_register),
        .first_value(first_value), .second_value(second_value),
        .sat_pos(sat_pos), .nzcv(nzcv), .sat_clear(sat_clear),
        .write_en(write_en), .write_index(write_index),
        .write_data(write_data), .nzcv_write_en(nzcv_write_en),
        .sat_flag(sat_flag));
    reg_file_model rf_u (.clk(clk), .write_en(write_en),
        .write_index(write_index), .write_data(write_data));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // one issue cycle; write-back is visible at the next falling edge
    task automatic do_op(input simd_alu_pkg::op_e o, input logic [3:0] p,
                         input logic [31:0] a, input logic [31:0] b);
        @(negedge clk);
        op = o;
        {issue, sat_pos, first_value, second_value} = {1'b1, p, a, b};
        @(negedge clk);
        issue = 1'b0;
    endtask : do_op
    task automatic t_add();
        {dest_present, dest_index, first_operand_register} = 9'h125;
        do_op(simd_alu_pkg::dual_lane_halving_add, 4'h0,
              32'h8000FFFD, 32'h80000000);
        chk({28'h0, write_index}, 32'h2);
        chk(write_data, 32'h8000FFFE);
        dest_present = 1'b0;
        do_op(simd_alu_pkg::quad_lane_halving_add, 4'h0,
              32'h7F80FF01, 32'h7F80FE03);
        chk({28'h0, write_index}, 32'h5);
        chk(write_data, 32'h7F80FE02);
        chk({31'h0, nzcv_write_en}, 32'h0);
        chk(rf_u.regs[2], 32'h8000FFFE);
    endtask : t_add
    // unsigned, position, source, result, flag
    localparam logic [69:0] CL [6] = '{
        {1'b0, 4'hF, 32'h7FFF8000, 32'h7FFF8000, 1'b0},
        {1'b0, 4'h8, 32'h7FFF8000, 32'h00FFFF00, 1'b1},
        {1'b0, 4'h0, 32'h0001FFFF, 32'h0000FFFF, 1'b1},
        {1'b1, 4'hF, 32'h7FFF0005, 32'h7FFF0005, 1'b0},
        {1'b1, 4'h8, 32'h0100FFFF, 32'h00FF0000, 1'b1},
        {1'b1, 4'h0, 32'h00000000, 32'h00000000, 1'b0}};
    task automatic t_clamp();
        logic u, f;
        logic [3:0] p;
        logic [31:0] v, e;
        for (int i = 0; i < 6; i++) begin
            {u, p, v, e, f} = CL[i];
            sat_clear = 1'b1;
            @(negedge clk);
            sat_clear = 1'b0;
            chk({31'h0, sat_flag}, 32'h0);
            do_op(u ? simd_alu_pkg::dual_unsigned_clamp
                    : simd_alu_pkg::dual_signed_clamp, p, '1, v);
            chk(write_data, e);
            chk({31'h0, sat_flag}, {31'h0, f});
            chk({31'h0, nzcv_write_en}, 32'h0);
            // one idle cycle without clear: the flag must stick
            @(negedge clk);
            chk({31'h0, sat_flag}, {31'h0, f});
        end
    endtask : t_clamp
    // pass pattern of all sixteen predicates with only the zero flag set
    localparam logic [15:0] PASS = 16'hE6A9;
    task automatic t_pred();
        logic [31:0] prev;
        prev = write_data;
        nzcv = 4'h4;
        for (int i = 0; i < 16; i++) begin
            cond = simd_alu_pkg::cond_e'(i);
            do_op(simd_alu_pkg::dual_lane_halving_add, 4'h0, i, i);
            if (PASS[i]) prev = i;
            chk({31'h0, write_en}, {31'h0, PASS[i]});
            chk(write_data, prev);
        end
        cond = simd_alu_pkg::cond_ne;
        do_op(simd_alu_pkg::dual_signed_clamp, 4'h0, '0, 32'h7FFF7FFF);
        chk({31'h0, sat_flag}, 32'h0);
        chk({31'h0, write_en}, 32'h0);
        chk(write_data, prev);
    endtask : t_pred
    initial begin
        {issue, dest_present, sat_clear, reset_n} = '0;
        {dest_index, first_operand_register, sat_pos, nzcv} = '0;
        {first_value, second_value} = '0;
        op = simd_alu_pkg::dual_lane_halving_add;
        cond = simd_alu_pkg::cond_al;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        chk(write_data, simd_alu_pkg::RESULT_RESET);
        chk({31'h0, write_en}, 32'h0);
        chk({31'h0, sat_flag}, {31'h0, simd_alu_pkg::SAT_RESET});
        t_add();
        t_clamp();
        t_pred();
        print_verdict();
    end
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
